// *** hw/ttc_pkg.sv ***
// Package: register map, field layout, reset values and counts for the thermal throttle controller
package ttc_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] TTC_OFS_DEMAND = 8'h00;  // On-demand control
    localparam logic [7:0] TTC_OFS_AUTO = 8'h04;    // Automatic mode enables
    localparam logic [7:0] TTC_OFS_OPPT = 8'h08;    // Requested operating point
    localparam logic [7:0] TTC_OFS_STATUS = 8'h0C;  // Live status

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int TTC_DEM_EN_BIT = 4;
    localparam int TTC_DEM_DUTY_LO = 1;
    localparam int TTC_AUTO_GATE_BIT = 0;
    localparam int TTC_AUTO_OPPT_BIT = 1;
    localparam int TTC_OPPT_W = 4;

    // ----------------------------------------------------------------
    // Reset values and constants
    // ----------------------------------------------------------------
    localparam logic [4:0] TTC_DEMAND_RST = 5'h00;
    localparam logic [1:0] TTC_AUTO_RST = 2'h0;
    localparam logic [3:0] TTC_OPPT_RST = 4'hF;
    localparam logic [3:0] TTC_LOWEST_PT = 4'h0;      // Lowest frequency point code
    localparam logic [2:0] TTC_AUTO_DUTY = 3'h4;      // Fixed 50 % (4 of 8 slots)
    localparam int TTC_CORE_MHZ = 100;
    localparam int TTC_SLOT_NS = 80;                  // Gating slot length at this clock
    localparam int TTC_SLOT_CYC = (TTC_SLOT_NS * TTC_CORE_MHZ) / 1000;
    localparam logic [7:0] TTC_SLOT_LAST = 8'(TTC_SLOT_CYC - 1);
    localparam int TTC_HYST_CYC = 64;                 // Cool time before release
    localparam logic [7:0] TTC_HYST_LAST = 8'(TTC_HYST_CYC - 1);

    typedef enum {TTC_IDLE, TTC_GATE, TTC_LOWPT} ttc_state_t;

endpackage

// *** hw/ttc_thermal_throttle_control.sv ***
// Thermal throttle controller: clock gating and operating-point throttling with Wishbone registers
`timescale 1ns/1ps

module ttc_thermal_throttle_control (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Sensor and interrupt inputs
    input wire logic sensor_hot,
    input wire logic irq_req,
    // Clock tree, operating point and core outputs
    output logic core_clk_en,
    output logic [ttc_pkg::TTC_OPPT_W-1:0] oppt_target,
    output logic snoop_en,
    output logic irq_deliver,
    output logic thermal_throttle_circuit,
    output logic overtemp_indicator_n
);
    import ttc_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [2:0] hot_sync_r, hot_sync_nxt;
    logic hot_r, hot_nxt;
    logic [4:0] demand_r, demand_nxt;
    logic [1:0] auto_r, auto_nxt;
    logic [3:0] oppt_req_r, oppt_req_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt;
    ttc_state_t state_r, state_nxt;
    logic [7:0] hyst_r, hyst_nxt;
    logic [7:0] slot_r, slot_nxt;
    logic [2:0] phase_r, phase_nxt;
    logic clk_en_r, clk_en_nxt;
    logic [3:0] oppt_out_r, oppt_out_nxt;
    logic irq_pend_r, irq_pend_nxt;
    logic irq_out_r, irq_out_nxt;
    logic tcc_r, tcc_nxt;
    logic hot_n_r, hot_n_nxt;
    logic snoop_r, snoop_nxt;
    logic wb_req;
    logic auto_active;
    logic demand_active;
    logic [2:0] duty;

    // Byte-lane merge for a register field
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] sel);
        lane0 = sel[0] ? d[7:0] : old;
    endfunction

    // True while the die is cool but the release run has not yet elapsed
    function automatic logic cool_wait(input logic hot, input logic [7:0] cnt);
        cool_wait = !hot && (cnt != TTC_HYST_LAST);
    endfunction

    // One step of an eight-bit cycle counter
    function automatic logic [7:0] step8(input logic [7:0] cnt);
        step8 = cnt + 8'h01;
    endfunction

    // The operating-point variant is wanted: hot, and its enable bit set
    function automatic logic lowpt_wanted(input logic hot, input logic [1:0] mode);
        lowpt_wanted = hot && mode[TTC_AUTO_OPPT_BIT];
    endfunction

    // ----------------------------------------------------------------
    // Sensor synchroniser and hot tracking
    // ----------------------------------------------------------------
    // Three stages; the flag only changes once stages two and three agree.
    // The first stage may go metastable, so only the shift reads it, and a
    // one-cycle glitch on the sensor never reaches the throttle.
    always_comb begin
        hot_sync_nxt = {hot_sync_r[1:0], sensor_hot};
        hot_nxt = hot_r;
        if (hot_sync_r[1] == hot_sync_r[2]) begin
            hot_nxt = hot_sync_r[2];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hot_sync_r <= 3'h0;
            hot_r <= 1'b0;
        end else begin
            hot_sync_r <= hot_sync_nxt;
            hot_r <= hot_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Wishbone register file
    // ----------------------------------------------------------------
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;

    // Map: 0x00 on-demand (bit 4 enable, bits 3:1 duty), 0x04 automatic enables
    // (bit 0 gating, bit 1 operating point), 0x08 requested operating point,
    // 0x0C live status: bit 0 hot, bit 3 throttle, bit 4 gating, bit 5 lowest
    // point, bit 6 core clocks running, bit 7 interrupt pending.
    // Only byte lane 0 holds register bits; the other lanes are ignored.
    // A request is taken on an edge with cyc and stb high and ack low, and is
    // refused while ack is high, so a strobe still held is not taken twice.
    // Single-cycle answer; ack drops the cycle after it is given
    always_comb begin
        demand_nxt = demand_r;
        auto_nxt = auto_r;
        oppt_req_nxt = oppt_req_r;
        dat_nxt = dat_r;
        ack_nxt = wb_req;
        if (wb_req && wb_we_i) begin
            if (wb_adr_i == TTC_OFS_DEMAND) begin
                demand_nxt = 5'(lane0({3'h0, demand_r}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == TTC_OFS_AUTO) begin
                auto_nxt = 2'(lane0({6'h00, auto_r}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == TTC_OFS_OPPT) begin
                oppt_req_nxt = 4'(lane0({4'h0, oppt_req_r}, wb_dat_i, wb_sel_i));
            end
        end
        if (wb_req && !wb_we_i) begin
            if (wb_adr_i == TTC_OFS_DEMAND) begin
                dat_nxt = {27'h0, demand_r};
            end else if (wb_adr_i == TTC_OFS_AUTO) begin
                dat_nxt = {30'h0, auto_r};
            end else if (wb_adr_i == TTC_OFS_OPPT) begin
                dat_nxt = {28'h0, oppt_req_r};
            end else if (wb_adr_i == TTC_OFS_STATUS) begin
                dat_nxt = {24'h0, irq_pend_r, clk_en_r, state_r == TTC_LOWPT,
                           state_r == TTC_GATE, tcc_r, 2'h0, hot_r};
            end else begin
                dat_nxt = 32'h0;  // Unmapped reads return zero
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            demand_r <= TTC_DEMAND_RST;
            auto_r <= TTC_AUTO_RST;
            oppt_req_r <= TTC_OPPT_RST;
            dat_r <= 32'h0;
            ack_r <= 1'b0;
        end else begin
            demand_r <= demand_nxt;
            auto_r <= auto_nxt;
            oppt_req_r <= oppt_req_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Throttle state machine
    // ----------------------------------------------------------------
    assign auto_active = hot_r && (auto_r != 2'h0);
    assign demand_active = demand_r[TTC_DEM_EN_BIT];

    // Hysteresis: the die must stay cool for a run of cycles before release.
    // Priority: the operating-point variant first, then clock gating, with
    // on-demand opening the gate on its own and holding it open once the automatic cause is gone.
    // Any change of state restarts the cool run, so a release never inherits
    // a count that was built up in another state.
    always_comb begin
        state_nxt = state_r;
        hyst_nxt = hot_r ? 8'h00 : hyst_r;
        case (state_r)
            TTC_IDLE: begin
                if (lowpt_wanted(hot_r, auto_r)) begin
                    state_nxt = TTC_LOWPT;
                end else if (auto_active || demand_active) begin
                    state_nxt = TTC_GATE;
                end
            end
            TTC_GATE: begin
                if (lowpt_wanted(hot_r, auto_r)) begin
                    state_nxt = TTC_LOWPT;
                end else if (cool_wait(hot_r, hyst_r)) begin
                    hyst_nxt = step8(hyst_r);
                end else if (!hot_r || auto_r == 2'h0) begin
                    if (!demand_active) begin
                        state_nxt = TTC_IDLE;
                    end
                end
            end
            TTC_LOWPT: begin
                if (cool_wait(hot_r, hyst_r)) begin
                    hyst_nxt = step8(hyst_r);
                end else if (!lowpt_wanted(hot_r, auto_r)) begin
                    state_nxt = demand_active ? TTC_GATE : TTC_IDLE;
                end
            end
            default: state_nxt = TTC_IDLE;
        endcase
        if (state_nxt != state_r) begin
            hyst_nxt = 8'h00;
        end
    end

    // Automatic gating owns the duty whenever it is hot and either automatic enable is set; on-demand only when not
    assign duty = auto_active ? TTC_AUTO_DUTY : demand_r[TTC_DEM_DUTY_LO +: 3];

    // Only the state and its cool-run counter are registered here; the
    // outputs below are registered again so every port comes from a flop
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r <= TTC_IDLE;
            hyst_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            hyst_r <= hyst_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Clock modulation
    // ----------------------------------------------------------------
    // Eight slots per period, each TTC_SLOT_NS long and turned into core clocks by TTC_CORE_MHZ, so the
    // period stays 640 ns whatever the core clock; a zero duty code is treated as one slot on.
    // Phase zero always runs, so no stopped stretch can outlast seven slots,
    // which bounds how long a latched interrupt has to wait.
    always_comb begin
        slot_nxt = slot_r;
        phase_nxt = phase_r;
        clk_en_nxt = 1'b1;
        if (state_r == TTC_GATE) begin
            if (slot_r == TTC_SLOT_LAST) begin
                slot_nxt = 8'h00;
                phase_nxt = phase_r + 3'h1;
            end else begin
                slot_nxt = step8(slot_r);
            end
            clk_en_nxt = (phase_r < duty) || (duty == 3'h0 && phase_r == 3'h0);
        end else begin
            slot_nxt = 8'h00;
            phase_nxt = 3'h0;
        end
    end

    // Gating restarts at phase zero on every entry
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            slot_r <= 8'h00;
            phase_r <= 3'h0;
            clk_en_r <= 1'b1;
        end else begin
            slot_r <= slot_nxt;
            phase_r <= phase_nxt;
            clk_en_r <= clk_en_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Operating point and throttle indicators
    // ----------------------------------------------------------------
    // The request register keeps the last wish, so the return after cooling
    // needs no copy taken at the moment throttling began.
    always_comb begin
        oppt_out_nxt = (state_r == TTC_LOWPT) ? TTC_LOWEST_PT : oppt_req_r;
        tcc_nxt = state_r != TTC_IDLE;
        hot_n_nxt = !hot_r;
        snoop_nxt = 1'b1;
    end

    // Snooping is never gated, so its flop only leaves reset at one
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            oppt_out_r <= TTC_OPPT_RST;
            tcc_r <= 1'b0;
            hot_n_r <= 1'b1;
            snoop_r <= 1'b1;
        end else begin
            oppt_out_r <= oppt_out_nxt;
            tcc_r <= tcc_nxt;
            hot_n_r <= hot_n_nxt;
            snoop_r <= snoop_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt latch
    // ----------------------------------------------------------------
    // Latched interrupts wait for a running-clock slot; a new request wins over the release
    // so a request arriving in the release cycle is never lost.
    always_comb begin
        irq_out_nxt = irq_pend_r && clk_en_r;
        irq_pend_nxt = (irq_pend_r && !irq_out_nxt) || irq_req;
    end

    // Pending flag and the one-cycle release pulse
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_pend_r <= 1'b0;
            irq_out_r <= 1'b0;
        end else begin
            irq_pend_r <= irq_pend_nxt;
            irq_out_r <= irq_out_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Output drive
    // ----------------------------------------------------------------
    // Every port below is a flop output, so no decode glitch reaches the pins
    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign core_clk_en = clk_en_r;
    assign oppt_target = oppt_out_r;
    assign snoop_en = snoop_r;
    assign irq_deliver = irq_out_r;
    assign thermal_throttle_circuit = tcc_r;
    assign overtemp_indicator_n = hot_n_r;

endmodule // ttc_thermal_throttle_control

// *** verif/ttc_props.sv ***
// Checker: concurrent properties on the thermal throttle controller ports
`timescale 1ns/1ps

module ttc_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Sensor and core side
    input wire logic sensor_hot,
    input wire logic irq_deliver,
    input wire logic core_clk_en,
    input wire logic snoop_en,
    input wire logic thermal_throttle_circuit,
    input wire logic overtemp_indicator_n
);
    // Length of the current clock-stopped stretch; saturates so it cannot wrap back into range
    logic [6:0] off_cnt_r;
    logic [6:0] off_cnt_nxt;
    always_comb off_cnt_nxt = core_clk_en ? 7'h00 : ((off_cnt_r == 7'h7F) ? off_cnt_r : off_cnt_r + 7'h01);
    always_ff @(posedge clk_sys or posedge reset) off_cnt_r <= reset ? 7'h00 : off_cnt_nxt;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_snoop_on: assert property (snoop_en) else $error("snooping stopped");
    chk_irq_running: assert property (irq_deliver |-> $past(core_clk_en)) else $error("irq while clocks off");
    chk_hot_flag: assert property (sensor_hot [*8] |-> !overtemp_indicator_n) else $error("hot flag missing");
    chk_cool_flag: assert property (!sensor_hot [*8] |-> overtemp_indicator_n) else $error("hot flag stuck");
    chk_run_idle: assert property (!thermal_throttle_circuit [*2] |-> core_clk_en) else $error("clock off idle");
    chk_stop_cause: assert property ($fell(core_clk_en) |-> thermal_throttle_circuit) else $error("stray stop");
    chk_gap_bound: assert property (off_cnt_r <= 7'h38) else $error("clock off beyond seven slots");
    chk_hyst_hold: assert property (thermal_throttle_circuit && sensor_hot ##1 !sensor_hot
        |=> thermal_throttle_circuit [*8]) else $error("released without hysteresis");
endmodule // ttc_props

bind ttc_thermal_throttle_control ttc_props u_props (.clk_sys(clk_sys), .reset(reset), .sensor_hot(sensor_hot),
    .irq_deliver(irq_deliver), .core_clk_en(core_clk_en), .snoop_en(snoop_en),
    .thermal_throttle_circuit(thermal_throttle_circuit), .overtemp_indicator_n(overtemp_indicator_n));

// *** verif/ttc_core_model.sv ***
// Partner model: core clock tree and operating-point controller behind the throttle outputs
`timescale 1ns/1ps

module ttc_core_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Controller outputs
    input wire logic core_clk_en,
    input wire logic [3:0] oppt_target,
    input wire logic irq_deliver,
    // Observed core state
    output logic [15:0] run_cnt,
    output logic [3:0] cur_pt,
    output logic [7:0] irq_cnt
);
    // Counts core edges that really run; users take differences, so wrap is harmless
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            run_cnt <= 16'h0000;
            cur_pt <= 4'hF;
            irq_cnt <= 8'h00;
        end else begin
            run_cnt <= run_cnt + {15'h0000, core_clk_en};
            cur_pt <= oppt_target;
            irq_cnt <= irq_cnt + {7'h00, irq_deliver};
        end
    end
endmodule // ttc_core_model

// *** verif/ttc_thermal_throttle_control_bench.sv ***
// Testbench: self-checking run of the thermal throttle controller with its core model
`timescale 1ns/1ps

module ttc_thermal_throttle_control_bench;
    import ttc_pkg::*;
    logic clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sensor_hot, irq_req;
    logic core_clk_en, snoop_en, irq_deliver, thermal_throttle_circuit, overtemp_indicator_n;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic [3:0] oppt_target;
    logic [3:0] cur_pt;
    logic [15:0] run_cnt;
    logic [7:0] irq_cnt;
    logic [31:0] exp_q[$];
    int n_errors = 0;
    int comparisons = 0;

    ttc_thermal_throttle_control u_dut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sensor_hot(sensor_hot), .irq_req(irq_req),
        .core_clk_en(core_clk_en), .oppt_target(oppt_target), .snoop_en(snoop_en), .irq_deliver(irq_deliver),
        .thermal_throttle_circuit(thermal_throttle_circuit), .overtemp_indicator_n(overtemp_indicator_n));
    ttc_core_model u_model (.clk_sys(clk_sys), .reset(reset), .core_clk_en(core_clk_en),
        .oppt_target(oppt_target), .irq_deliver(irq_deliver), .run_cnt(run_cnt), .cur_pt(cur_pt), .irq_cnt(irq_cnt));

    // 100 MHz core clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Classic cycle: held until ack is sampled, then idle one cycle so ack can drop
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, adr, 32'h00000000);
    endtask

    // Running core edges over one full 64-cycle gating period, after settling
    task automatic duty(input string nm, input int on);
        logic [15:0] s;
        repeat (200) @(posedge clk_sys);
        s = run_cnt;
        repeat (64) @(posedge clk_sys);
        chk(nm, on, run_cnt - s);
    endtask

    // Read data is matched at the ack edge, while the request is still held
    always @(posedge clk_sys) if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk("rdata", exp_q.pop_front(), wb_dat_o);

    // Hang guard: the sequence needs well under 10000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        print_verdict();
    end

    initial begin
        logic [7:0] ic;
        logic [3:0] pt;
        reset = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, sensor_hot, irq_req} = 5'h00;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h00000000;
        void'($urandom(1966));
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk("hot_n", 1, overtemp_indicator_n);
        rd(TTC_OFS_DEMAND, {27'h0, TTC_DEMAND_RST});
        rd(TTC_OFS_OPPT, {28'h0, TTC_OPPT_RST});
        rd(TTC_OFS_AUTO, {30'h0, TTC_AUTO_RST});
        rd(TTC_OFS_STATUS, 32'h00000040);
        rd(8'h10, 32'h00000000);
        // On-demand duty in every step; a zero field runs one slot in eight
        for (int d = 0; d < 8; d++) begin
            wb(1'b1, TTC_OFS_DEMAND, 32'h10 | (d << 1));
            duty("demand_duty", ((d == 0) ? 1 : d) * 8);
            chk("throttle", 1, thermal_throttle_circuit);
        end
        rd(TTC_OFS_DEMAND, 32'h1E);
        wb(1'b1, TTC_OFS_AUTO, 32'h1);
        duty("cool_demand", 56);
        sensor_hot <= 1'b1;
        duty("auto_duty", 32);
        chk("hot_n", 0, overtemp_indicator_n);
        ic = irq_cnt;
        irq_req <= 1'b1;
        @(posedge clk_sys);
        irq_req <= 1'b0;
        repeat (80) @(posedge clk_sys);
        chk("irq_once", 1, irq_cnt - ic);
        wb(1'b1, TTC_OFS_DEMAND, 32'h0);
        sensor_hot <= 1'b0;
        repeat (30) @(posedge clk_sys);
        chk("hyst", 1, thermal_throttle_circuit);
        duty("released", 64);
        chk("throttle", 0, thermal_throttle_circuit);
        // Both variants on: lowest point while hot, last request once cool
        pt = 4'($urandom_range(15, 1));
        wb(1'b1, TTC_OFS_OPPT, {28'h0, pt});
        wb(1'b1, TTC_OFS_AUTO, 32'h3);
        sensor_hot <= 1'b1;
        duty("oppt_no_gate", 64);
        chk("lowest", TTC_LOWEST_PT, cur_pt);
        rd(TTC_OFS_STATUS, 32'h00000069);
        sensor_hot <= 1'b0;
        duty("oppt_cool", 64);
        chk("restored", pt, cur_pt);
        print_verdict();
    end
endmodule // ttc_thermal_throttle_control_bench
